// file: sen_pkg.sv
// Constants for the state-enable register bank: address fields, privilege
// encodings, field positions, reset values and default implementation masks.
// Assumes the privilege logic encodes modes as below.
package sen_pkg;
  localparam int SEN_NUM_REGS = 4;
  localparam int SEN_REG_W = 64;
  localparam int SEN_ADDR_W = 6;
  // Register address fields: addr[5:4] level, addr[3] high half, addr[2] zero, addr[1:0] index
  localparam int SEN_LVL_MSB = 5;
  localparam int SEN_LVL_LSB = 4;
  localparam int SEN_HI_BIT = 3;
  localparam int SEN_PAD_BIT = 2;
  localparam int SEN_IDX_MSB = 1;
  localparam logic [1:0] SEN_LVL_M = 2'h0;
  localparam logic [1:0] SEN_LVL_H = 2'h1;
  localparam logic [1:0] SEN_LVL_S = 2'h2;
  // Privilege encodings
  localparam logic [1:0] SEN_PRIV_U = 2'h0;
  localparam logic [1:0] SEN_PRIV_S = 2'h1;
  localparam logic [1:0] SEN_PRIV_M = 2'h3;
  // Field positions
  localparam int SEN_GATE_BIT = 63;
  localparam int SEN_HALF_W = 32;
  // Reset value of every writable bit
  localparam logic [63:0] SEN_RESET_VAL = 64'h0;
  localparam logic [63:0] SEN_LOW_HALF = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] SEN_HIGH_HALF = 64'hffff_ffff_0000_0000;
  localparam logic [63:0] SEN_GATE_MASK = 64'h8000_0000_0000_0000;
  // Default implemented bits: index 0 gate, upper controls and three low enables
  localparam logic [3:0][63:0] SEN_IMPL_DFLT = {64'h8000_0000_0000_0000,
    64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000, 64'hff00_0000_0000_0007};
  localparam logic [3:0][63:0] SEN_ZERO4 = {4{64'h0}};
endpackage : sen_pkg

// file: sen_state_enable.sv
// State-enable register bank with access checks for governed state and for
// the bank's own registers.
// Assumes a single clock, synchronous request inputs and a privilege unit that
// turns the one-cycle fault pulses into the matching exceptions.
`timescale 1ns/100ps

module sen_state_enable
  import sen_pkg::*;
#(
  parameter int XLEN = 64,
  parameter bit HAS_S = 1'b1,
  parameter bit HAS_H = 1'b1,
  parameter logic [3:0][63:0] M_IMPL = SEN_IMPL_DFLT,
  parameter logic [3:0][63:0] M_RO1 = SEN_ZERO4,
  parameter logic [3:0][63:0] H_RO1 = SEN_ZERO4,
  parameter logic [3:0][63:0] S_RO1 = SEN_ZERO4,
  parameter logic [3:0][63:0] S_RO0 = SEN_ZERO4,
  parameter bit M_GATE_FIXED0 = 1'b0
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [SEN_ADDR_W-1:0] reg_addr,
  input wire logic [XLEN-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_priv,
  input wire logic reg_virt,
  output logic [XLEN-1:0] reg_rdata,
  output logic reg_illegal,
  output logic reg_virtual,
  input wire logic chk_valid,
  input wire logic [1:0] chk_idx,
  input wire logic [5:0] chk_bit,
  input wire logic [1:0] chk_priv,
  input wire logic chk_virt,
  output logic chk_done,
  output logic chk_allow,
  output logic chk_illegal,
  output logic chk_virtual
);

  // All state of the bank, registered as one word
  typedef struct packed {
    logic [3:0][63:0] m;
    logic [3:0][63:0] h;
    logic [3:0][63:0] s;
    logic [XLEN-1:0] rdata;
    logic reg_ill;
    logic reg_vi;
    logic chk_done;
    logic chk_allow;
    logic chk_ill;
    logic chk_vi;
  } sen_state_t;

  // Fixed-one machine bits must be implemented
  function automatic logic [3:0][63:0] m_ro1_f();
    logic [3:0][63:0] r;
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      r[i] = M_RO1[i] & M_IMPL[i] & ~SEN_GATE_MASK;
    end
    return r;
  endfunction : m_ro1_f

  // Supervisor bits: low half of machine bits minus encroaching ones
  function automatic logic [3:0][63:0] s_impl_f();
    logic [3:0][63:0] r;
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      r[i] = HAS_S ? (M_IMPL[i] & SEN_LOW_HALF & ~S_RO0[i]) : 64'h0;
    end
    return r;
  endfunction : s_impl_f

  localparam logic [3:0][63:0] M_RO1E = m_ro1_f();
  localparam logic [3:0][63:0] S_IMPL = s_impl_f();

  function automatic logic [3:0][63:0] m_wr_f();
    logic [3:0][63:0] r;
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      r[i] = M_IMPL[i] & ~M_RO1E[i] & ~SEN_GATE_MASK;
      if (!(M_GATE_FIXED0 && !HAS_H && S_IMPL[i] == 64'h0))
      begin
        r[i] = r[i] | SEN_GATE_MASK;
      end
    end
    return r;
  endfunction : m_wr_f

  function automatic logic [3:0][63:0] h_ro1_f();
    logic [3:0][63:0] r;
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      r[i] = HAS_H ? (H_RO1[i] & M_RO1E[i] & ~SEN_GATE_MASK) : 64'h0;
    end
    return r;
  endfunction : h_ro1_f

  // Writable and fixed-one masks of each level
  localparam logic [3:0][63:0] M_WR = m_wr_f();
  localparam logic [3:0][63:0] H_RO1E = h_ro1_f();

  function automatic logic [3:0][63:0] h_wr_f();
    logic [3:0][63:0] r;
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      r[i] = HAS_H ? ((M_IMPL[i] & ~H_RO1E[i]) | SEN_GATE_MASK) : 64'h0;
    end
    return r;
  endfunction : h_wr_f

  function automatic logic [3:0][63:0] s_ro1_f();
    logic [3:0][63:0] r;
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      r[i] = S_RO1[i] & S_IMPL[i] & M_RO1E[i] & (HAS_H ? H_RO1E[i] : 64'hffff_ffff_ffff_ffff);
    end
    return r;
  endfunction : s_ro1_f

  localparam logic [3:0][63:0] H_WR = h_wr_f();
  localparam logic [3:0][63:0] S_RO1E = s_ro1_f();

  function automatic logic [3:0][63:0] s_wr_f();
    logic [3:0][63:0] r;
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      r[i] = S_IMPL[i] & ~S_RO1E[i];
    end
    return r;
  endfunction : s_wr_f

  localparam logic [3:0][63:0] S_WR = s_wr_f();

  // Merge a write into a stored value, only the lanes and bits in wmask
  function automatic logic [63:0] merge_f(logic [63:0] old, logic [XLEN-1:0] wd,
                                          logic hi, logic [63:0] wmask);
    logic [63:0] wide;
    logic [63:0] lane;
    wide = 64'(wd);
    lane = 64'hffff_ffff_ffff_ffff;
    if (XLEN == SEN_HALF_W)
    begin
      wide = hi ? (wide << SEN_HALF_W) : wide;
      lane = hi ? SEN_HIGH_HALF : SEN_LOW_HALF;
    end
    return (old & ~(wmask & lane)) | (wide & wmask & lane);
  endfunction : merge_f

  // Effective value: stored writable bits, fixed ones, cut by the level above
  function automatic logic [63:0] eff_f(logic [63:0] stored, logic [63:0] wmask,
                                        logic [63:0] ro1, logic [63:0] above);
    return ((stored & wmask) | ro1) & above;
  endfunction : eff_f

  // Supervisor view: a guest also sees the hypervisor cut
  function automatic logic [63:0] sup_view_f(logic [3:0][63:0] s_all,
                                             logic [3:0][63:0] vs_all,
                                             logic [1:0] idx, logic virt);
    return virt ? vs_all[idx] : s_all[idx];
  endfunction : sup_view_f

  // High halves exist only on a 32-bit hart
  function automatic logic hi_ok_f(logic hi);
    return !hi || XLEN == SEN_HALF_W;
  endfunction : hi_ok_f

  // Register access permission: {illegal, virtual}
  function automatic logic [1:0] reg_perm_f(logic [1:0] lvl, logic [1:0] priv, logic virt,
                                            logic m_gate, logic h_gate);
    logic [1:0] r;
    r = 2'h0;
    if (priv != SEN_PRIV_M)
    begin
      case (lvl)
        SEN_LVL_M: r = 2'h2;
        SEN_LVL_H:
        begin
          if (virt)
            r = 2'h1;
          else if (priv == SEN_PRIV_U || !m_gate)
            r = 2'h2;
        end
        SEN_LVL_S:
        begin
          if (priv == SEN_PRIV_U)
            r = virt ? 2'h1 : 2'h2;
          else if (!m_gate)
            r = 2'h2;
          else if (virt && !h_gate)
            r = 2'h1;
        end
        default: r = 2'h2;
      endcase
    end
    return r;
  endfunction : reg_perm_f

  // Bits a write may change, given the level and the accessor's mode
  function automatic logic [63:0] wmask_f(logic [1:0] lvl, logic [1:0] idx, logic virt,
                                          logic [3:0][63:0] m_all, logic [3:0][63:0] h_all);
    logic [63:0] r;
    case (lvl)
      SEN_LVL_M: r = M_WR[idx];
      SEN_LVL_H: r = H_WR[idx] & m_all[idx];
      SEN_LVL_S: r = S_WR[idx] & (virt ? h_all[idx] | ~H_WR[idx] : m_all[idx]);
      default: r = 64'h0;
    endcase
    return r;
  endfunction : wmask_f

  sen_state_t q;
  sen_state_t d;
  logic [3:0][63:0] m_eff;
  logic [3:0][63:0] h_eff;
  logic [3:0][63:0] s_eff;
  logic [3:0][63:0] s_eff_vs;

  // Effective views of every level
  always_comb
  begin
    for (int i = 0; i < SEN_NUM_REGS; i++)
    begin
      m_eff[i] = eff_f(q.m[i], M_WR[i], M_RO1E[i], '1);
      h_eff[i] = eff_f(q.h[i], H_WR[i], H_RO1E[i], m_eff[i]);
      s_eff[i] = eff_f(q.s[i], S_WR[i], S_RO1E[i], m_eff[i]);
      s_eff_vs[i] = HAS_H ? (s_eff[i] & h_eff[i]) : s_eff[i];
    end
  end

  // Decoded register request
  logic [1:0] r_lvl;
  logic [1:0] r_idx;
  logic r_hi;
  logic r_mapped;
  logic [1:0] r_perm;
  logic [63:0] r_val;
  logic [63:0] c_m;
  logic [63:0] c_h;
  logic [63:0] c_s;
  logic [63:0] w_mask;

  // Address decode, permission and read selection
  always_comb
  begin
    r_lvl = reg_addr[SEN_LVL_MSB:SEN_LVL_LSB];
    r_idx = reg_addr[SEN_IDX_MSB:0];
    r_hi = reg_addr[SEN_HI_BIT];
    r_mapped = !reg_addr[SEN_PAD_BIT];
    case (r_lvl)
      SEN_LVL_M: r_mapped = r_mapped && hi_ok_f(r_hi);
      SEN_LVL_H: r_mapped = r_mapped && HAS_H && hi_ok_f(r_hi);
      SEN_LVL_S: r_mapped = r_mapped && HAS_S && !r_hi;
      default: r_mapped = 1'b0;
    endcase
    r_perm = r_mapped ? reg_perm_f(r_lvl, reg_priv, reg_virt,
                                   m_eff[r_idx][SEN_GATE_BIT], h_eff[r_idx][SEN_GATE_BIT])
                      : 2'h2;
    case (r_lvl)
      SEN_LVL_M: r_val = m_eff[r_idx];
      SEN_LVL_H: r_val = h_eff[r_idx];
      SEN_LVL_S: r_val = sup_view_f(s_eff, s_eff_vs, r_idx, reg_virt);
      default: r_val = 64'h0;
    endcase
    w_mask = wmask_f(r_lvl, r_idx, reg_virt, m_eff, h_eff);
    c_m = m_eff[chk_idx];
    c_h = h_eff[chk_idx];
    c_s = sup_view_f(s_eff, s_eff_vs, chk_idx, chk_virt);
  end

  // Next state
  always_comb
  begin
    d = q;
    d.rdata = '0;
    d.reg_ill = 1'b0;
    d.reg_vi = 1'b0;
    d.chk_done = chk_valid;
    d.chk_allow = 1'b0;
    d.chk_ill = 1'b0;
    d.chk_vi = 1'b0;
    if (reg_rd || reg_wr)
    begin
      d.reg_ill = r_perm[1];
      d.reg_vi = r_perm[0];
    end
    if (reg_rd && r_perm == 2'h0)
    begin
      if (XLEN == SEN_HALF_W && r_hi)
        d.rdata = XLEN'(r_val[63:SEN_HALF_W]);
      else
        d.rdata = XLEN'(r_val);
    end
    if (reg_wr && r_perm == 2'h0)
    begin
      case (r_lvl)
        SEN_LVL_M: d.m[r_idx] = merge_f(q.m[r_idx], reg_wdata, r_hi, w_mask);
        SEN_LVL_H: d.h[r_idx] = merge_f(q.h[r_idx], reg_wdata, r_hi, w_mask);
        SEN_LVL_S: d.s[r_idx] = merge_f(q.s[r_idx], reg_wdata, r_hi, w_mask);
        default: d.m = q.m;
      endcase
    end
    if (chk_valid)
    begin
      if (chk_priv == SEN_PRIV_M)
        d.chk_allow = 1'b1;
      else if (!c_m[chk_bit])
        d.chk_ill = 1'b1;
      else if (chk_virt && HAS_H && !c_h[chk_bit])
        d.chk_vi = 1'b1;
      else if (chk_priv == SEN_PRIV_U && !c_s[chk_bit])
        d.chk_ill = 1'b1;
      else
        d.chk_allow = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q.m <= {SEN_NUM_REGS{SEN_RESET_VAL}};
      q.h <= {SEN_NUM_REGS{SEN_RESET_VAL}};
      q.s <= {SEN_NUM_REGS{SEN_RESET_VAL}};
      q.rdata <= '0;
      q.reg_ill <= 1'b0;
      q.reg_vi <= 1'b0;
      q.chk_done <= 1'b0;
      q.chk_allow <= 1'b0;
      q.chk_ill <= 1'b0;
      q.chk_vi <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state
  assign reg_rdata = q.rdata;
  assign reg_illegal = q.reg_ill;
  assign reg_virtual = q.reg_vi;
  assign chk_done = q.chk_done;
  assign chk_allow = q.chk_allow;
  assign chk_illegal = q.chk_ill;
  assign chk_virtual = q.chk_vi;

endmodule : sen_state_enable

// file: sen_state_enable_checker.sv
// Port checker for the state-enable bank
// Assumes one clock and nrst active low
`timescale 1ns/100ps
module sen_state_enable_checker
  import sen_pkg::*;
#(
  parameter int XLEN = 64
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [SEN_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_priv,
  input wire logic reg_virt,
  input wire logic [XLEN-1:0] reg_rdata,
  input wire logic reg_illegal,
  input wire logic reg_virtual,
  input wire logic chk_valid,
  input wire logic [1:0] chk_priv,
  input wire logic chk_virt,
  input wire logic chk_done,
  input wire logic chk_allow,
  input wire logic chk_illegal,
  input wire logic chk_virtual
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_rd_m;
    reg_rd && reg_priv == SEN_PRIV_M && !reg_virt;
  endsequence
  sequence s_rd_u;
    reg_rd && reg_priv == SEN_PRIV_U && !reg_virt;
  endsequence
  chk_done_time: assert property (chk_valid |=> chk_done)
    else $error("check answer missing");
  chk_no_spur: assert property (!chk_valid |=> !(chk_done || chk_allow || chk_illegal))
    else $error("check answer without request");
  chk_one_hot: assert property (chk_done |-> $onehot({chk_allow, chk_illegal, chk_virtual}))
    else $error("check result not one-hot");
  chk_own_mode: assert property (chk_valid && chk_priv == SEN_PRIV_M |=> chk_allow)
    else $error("machine mode refused");
  chk_virt_only: assert property (chk_valid && !chk_virt |=> !chk_virtual)
    else $error("virtual fault outside virtual mode");
  chk_rd_quiet: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data without read");
  chk_fault_cause: assert property (!(reg_rd || reg_wr) |=> !(reg_illegal || reg_virtual))
    else $error("fault without access");
  chk_m_own: assert property (s_rd_m ##0 reg_addr[5:2] == 4'h0 |=> !reg_illegal)
    else $error("machine read refused");
  chk_m_guard: assert property (s_rd_u ##0 reg_addr[5:4] == SEN_LVL_M |=> reg_illegal)
    else $error("user read of machine register");
  chk_unmapped_refused: assert property (reg_rd && reg_addr[5:4] == 2'h3 |=> reg_illegal)
    else $error("unmapped read not refused");
endmodule : sen_state_enable_checker

bind sen_state_enable sen_state_enable_checker #(.XLEN(XLEN)) sen_state_enable_checker_inst (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_priv(reg_priv), .reg_virt(reg_virt), .reg_rdata(reg_rdata),
  .reg_illegal(reg_illegal), .reg_virtual(reg_virtual), .chk_valid(chk_valid),
  .chk_priv(chk_priv), .chk_virt(chk_virt), .chk_done(chk_done), .chk_allow(chk_allow),
  .chk_illegal(chk_illegal), .chk_virtual(chk_virtual));

// file: sen_hart_model.sv
// Hart-side model issuing random access checks
// Assumes the bench seeds $urandom and raises en between register accesses
`timescale 1ns/100ps
module sen_hart_model
  import sen_pkg::*;
(
  input wire logic clk,
  input wire logic en,
  output logic chk_valid,
  output logic [1:0] chk_idx,
  output logic [5:0] chk_bit,
  output logic [1:0] chk_priv,
  output logic chk_virt
);
  logic [1:0] p;
  always @(posedge clk)
  begin
    p <= 2'($urandom % 3);
    chk_valid <= en & 1'($urandom);
    chk_idx <= ($urandom & 1) ? 2'h0 : 2'($urandom);
    chk_bit <= ($urandom & 1) ? 6'($urandom % 3) : 6'h3f - 6'($urandom % 8);
    chk_priv <= (p == 2'h2) ? SEN_PRIV_M : p;
    chk_virt <= (p != 2'h2) & 1'($urandom);
  end
endmodule : sen_hart_model

// file: test_state_enable_access_control.sv
// Testbench for the state-enable bank: register port and access checks
// Assumes the checker is bound and the hart model drives the check port
`timescale 1ns/100ps
module test_state_enable_access_control import sen_pkg::*;;
  logic clk, nrst, reg_wr, reg_rd, reg_virt, en, pend;
  logic [5:0] reg_addr;
  logic [63:0] reg_wdata, reg_rdata;
  logic [1:0] reg_priv, chk_idx, chk_priv;
  logic reg_illegal, reg_virtual, chk_valid, chk_virt;
  logic chk_done, chk_allow, chk_illegal, chk_virtual;
  logic [5:0] chk_bit;
  logic [63:0] ms[4], hs[4], ss[4];
  logic [65:0] rq[$], cq[$];
  int bad_count, tests_run, cyc;
  sen_state_enable sen_state_enable_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_priv(reg_priv),
    .reg_virt(reg_virt), .reg_rdata(reg_rdata), .reg_illegal(reg_illegal),
    .reg_virtual(reg_virtual), .chk_valid(chk_valid), .chk_idx(chk_idx), .chk_bit(chk_bit),
    .chk_priv(chk_priv), .chk_virt(chk_virt), .chk_done(chk_done), .chk_allow(chk_allow),
    .chk_illegal(chk_illegal), .chk_virtual(chk_virtual));
  sen_hart_model sen_hart_model_inst (.clk(clk), .en(en), .chk_valid(chk_valid),
    .chk_idx(chk_idx), .chk_bit(chk_bit), .chk_priv(chk_priv), .chk_virt(chk_virt));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [63:0] eff(input int l, input int i, input logic v);
    logic [63:0] m;
    logic [63:0] h;
    m = ms[i] & SEN_IMPL_DFLT[i];
    h = hs[i] & m;
    if (l == 0) return m;
    if (l == 1) return h;
    return ss[i] & m & (v ? h : '1);
  endfunction : eff
  function automatic logic [2:0] dec(input int i, input int b, input logic [1:0] p, input logic v);
    logic [63:0] m;
    logic [63:0] h;
    logic [63:0] s;
    m = eff(0, i, v);
    h = eff(1, i, v);
    s = eff(2, i, v);
    if (p == SEN_PRIV_M) return 3'h4;
    if (!m[b]) return 3'h2;
    if (v && !h[b]) return 3'h1;
    if (p == SEN_PRIV_U && !s[b]) return 3'h2;
    return 3'h4;
  endfunction : dec
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic cmp_reg(input logic [65:0] e, input logic [65:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_reg
  task automatic cmp_chk(input logic [65:0] e, input logic [2:0] g);
    cmp_reg(e, 66'(g));
  endtask : cmp_chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [63:0] d,
    input logic [1:0] p, input logic v, input logic [65:0] e);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    reg_priv <= p;
    reg_virt <= v;
    rq.push_back(e);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : acc
  task automatic rd(input logic [5:0] a, input logic [1:0] p, input logic v,
    input logic [1:0] f, input logic [63:0] e);
    acc(1'b0, a, 64'h0, p, v, {f, e});
  endtask : rd
  task automatic wr(input int l, input int i, input logic [63:0] d);
    if (l == 0) ms[i] = d;
    else if (l == 1) hs[i] = d & eff(0, i, 1'b0);
    else ss[i] = d & eff(0, i, 1'b0);
    acc(1'b1, 6'(16 * l + i), d, SEN_PRIV_M, 1'b0, 66'h0);
  endtask : wr
  task automatic run_chk(input int n);
    en <= 1'b1;
    repeat (n) @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : run_chk
  always @(posedge clk)
  begin
    pend <= reg_rd | reg_wr;
    cyc++;
    if (chk_valid)
      cq.push_back(66'(dec(chk_idx, chk_bit, chk_priv, chk_virt)));
    if (cyc == 5000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  always @(negedge clk)
  begin
    if (pend)
      cmp_reg(rq.pop_front(), {reg_illegal, reg_virtual, reg_rdata});
    if (chk_done)
      cmp_chk(cq.pop_front(), {chk_allow, chk_illegal, chk_virtual});
  end
  initial
  begin
    {nrst, reg_wr, reg_rd, reg_virt, en, reg_addr, reg_wdata, reg_priv} = '0;
    foreach (ms[i]) {ms[i], hs[i], ss[i]} = '0;
    {bad_count, tests_run, cyc} = '0;
    void'($urandom(32'h8c2e));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 12; k++)
      rd(6'(16 * (k / 4) + k % 4), SEN_PRIV_M, 1'b0, 2'h0, 64'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(0, i, {$urandom, $urandom} | SEN_GATE_MASK);
      rd(6'(i), SEN_PRIV_M, 1'b0, 2'h0, eff(0, i, 1'b0));
      wr(1, i, 64'h0);
      wr(2, i, 64'h0);
      wr(1, i, '1);
      wr(2, i, {32'h0, $urandom});
      wr(1, i, {$urandom, $urandom} | SEN_GATE_MASK);
      rd(6'(16 + i), SEN_PRIV_M, 1'b0, 2'h0, eff(1, i, 1'b0));
      rd(6'(32 + i), SEN_PRIV_M, 1'b0, 2'h0, eff(2, i, 1'b0));
      rd(6'(32 + i), SEN_PRIV_S, 1'b1, 2'h0, eff(2, i, 1'b1));
    end
    run_chk(300);
    rd(6'h11, SEN_PRIV_S, 1'b0, 2'h0, eff(1, 1, 1'b0));
    rd(6'h01, SEN_PRIV_S, 1'b0, 2'h2, 64'h0);
    rd(6'h10, SEN_PRIV_U, 1'b0, 2'h2, 64'h0);
    rd(6'h10, SEN_PRIV_S, 1'b1, 2'h1, 64'h0);
    rd(6'h21, SEN_PRIV_U, 1'b1, 2'h1, 64'h0);
    rd(6'h28, SEN_PRIV_M, 1'b0, 2'h2, 64'h0);
    rd(6'h30, SEN_PRIV_M, 1'b0, 2'h2, 64'h0);
    acc(1'b1, 6'h02, '1, SEN_PRIV_S, 1'b0, {2'h2, 64'h0});
    rd(6'h02, SEN_PRIV_M, 1'b0, 2'h0, eff(0, 2, 1'b0));
    wr(0, 0, 64'h5);
    rd(6'h20, SEN_PRIV_S, 1'b0, 2'h2, 64'h0);
    rd(6'h10, SEN_PRIV_S, 1'b0, 2'h2, 64'h0);
    rd(6'h10, SEN_PRIV_M, 1'b0, 2'h0, eff(1, 0, 1'b0));
    run_chk(300);
    cmp_reg(66'h0, 66'(rq.size() + cq.size()));
    report_and_stop();
  end
endmodule : test_state_enable_access_control
